/* File: design/fcw_params.svh */
// Purpose: constants for the fieldbus command window block
// Assumes: 16-byte output data area presented as parallel bytes
// Notes: header holds definitions only
`ifndef FCW_PARAMS_SVH
`define FCW_PARAMS_SVH

`define FCW_CMD_NONE 8'h00
`define FCW_CMD_WINDOW 8'hFA
`define FCW_CMD_WRITE 8'hFB
`define FCW_CMD_CLR_RST 8'hFC
`define FCW_BYTE_CMD 0
`define FCW_BYTE_CNT 1
`define FCW_BYTE_ADDR_HI 2
`define FCW_BYTE_ADDR_LO 3
`define FCW_BYTE_DATA 4
`define FCW_MAX_REGS 4'h6
`define FCW_WIN_REGS 4'hC
`define FCW_ADDR_RST 16'h0000
`define FCW_AREA_BYTES 16

`endif

/* File: design/fcw_pkg.sv */
// Purpose: types for the fieldbus command window block
// Assumes: nothing
// Notes: constants live in fcw_params.svh
`default_nettype none
package fcw_pkg;
   // one-hot command sequencer states
   typedef enum logic [2:0] {
      FCW_IDLE = 3'b001,
      FCW_WRITE = 3'b010,
      FCW_DONE = 3'b100
   } fcw_state_t;
endpackage : fcw_pkg
`default_nettype wire

/* File: design/fcw_change_det.sv */
// Purpose: detect a change of the command byte to a nonzero code
// Assumes: command byte synchronous to clk_i
// Notes: one pulse per change; zero code arms but never fires
`include "fcw_params.svh"
`default_nettype none
module fcw_change_det (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // command byte
   input wire logic [7:0] cmd_i,
   // change pulse and the code that caused it
   output logic fire_o,
   output logic [7:0] code_o
);
   logic [7:0] prev_r; // last sampled command byte

   // sample the byte each cycle
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         prev_r <= `FCW_CMD_NONE;
      end else begin
         prev_r <= cmd_i;
      end
   end

   // fire once per change to a nonzero code
   assign fire_o = (cmd_i != prev_r) && (cmd_i != `FCW_CMD_NONE);
   assign code_o = cmd_i;

   // a held code must not fire twice
   property p_no_refire;
      @(posedge clk_i) disable iff (!rstn_i)
      fire_o |=> !fire_o || (cmd_i != $past(cmd_i));
   endproperty
   a_no_refire: assert property (p_no_refire) else $error("command fired twice");

   // zero never fires
   property p_zero_quiet;
      @(posedge clk_i) disable iff (!rstn_i)
      (cmd_i == `FCW_CMD_NONE) |-> !fire_o;
   endproperty
   a_zero_quiet: assert property (p_zero_quiet) else $error("zero code fired");
endmodule : fcw_change_det
`default_nettype wire

/* File: design/fcw_top.sv */
// Purpose: command interpreter behind a 16-byte fieldbus output area
// Assumes: area bytes synchronous to clk_i, stable while a command runs
// Notes: register writes go out one per cycle on a simple strobe port
//
// Functional notes
// - code 251 writes byte-01 count registers
// - start address in bytes 02-03, MSB first
// - write data from byte 04, MSB first
// - integer value plus decimals as third register
// - code 250 sets twelve-register read window
// - code 252 clears program-reset status bit
// - other nonzero codes pass straight to executor
// - unused bytes and extra data ignored
// - at most six registers per write
`include "fcw_params.svh"
`default_nettype none
module fcw_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // output data area from the fieldbus master
   input wire logic [7:0] area_i [`FCW_AREA_BYTES],
   // program-reset event from the instrument
   input wire logic prog_rst_set_i,
   // holding register write port
   output logic wr_en_o,
   output logic [15:0] wr_addr_o,
   output logic [15:0] wr_data_o,
   // read window
   output logic [15:0] win_start_o,
   output logic [3:0] win_len_o,
   // status bit
   output logic prog_rst_o,
   // direct command pass-through
   output logic cmd_en_o,
   output logic [7:0] cmd_code_o,
   // sequencer busy
   output logic busy_o
);
   ////////////////////////////////////////////////////////////////////
   // declarations
   logic fire; // one-cycle new command
   logic [7:0] code; // current command code
   fcw_pkg::fcw_state_t state_r; // sequencer state
   logic [3:0] left_r; // registers still to write
   logic [3:0] idx_r; // register index within data area
   logic [15:0] base_r; // latched start address

   // 16-bit big-endian word from two area bytes
   function automatic logic [15:0] be16(input logic [7:0] hi, input logic [7:0] lo);
      be16 = {hi, lo};
   endfunction : be16

   // clamp a requested count to what the area can carry
   function automatic logic [3:0] clamp_cnt(input logic [7:0] n);
      clamp_cnt = (n > 8'(`FCW_MAX_REGS)) ? `FCW_MAX_REGS : n[3:0];
   endfunction : clamp_cnt

   ////////////////////////////////////////////////////////////////////
   // change detector
   fcw_change_det u_det (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .cmd_i(area_i[`FCW_BYTE_CMD]),
      .fire_o(fire),
      .code_o(code)
   );

   ////////////////////////////////////////////////////////////////////
   // write sequencer state
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state_r <= fcw_pkg::FCW_IDLE;
         left_r <= 4'h0;
         idx_r <= 4'h0;
         base_r <= `FCW_ADDR_RST;
      end else begin
         case (state_r)
            fcw_pkg::FCW_IDLE: begin
               // latch count and address on a write command
               if (fire && code == `FCW_CMD_WRITE) begin
                  left_r <= clamp_cnt(area_i[`FCW_BYTE_CNT]);
                  base_r <= be16(area_i[`FCW_BYTE_ADDR_HI], area_i[`FCW_BYTE_ADDR_LO]);
                  idx_r <= 4'h0;
                  state_r <= fcw_pkg::FCW_WRITE;
               end
            end
            fcw_pkg::FCW_WRITE: begin
               // one register per cycle until count spent
               if (left_r == 4'h0) begin
                  state_r <= fcw_pkg::FCW_DONE;
               end else begin
                  left_r <= left_r - 4'h1;
                  idx_r <= idx_r + 4'h1;
               end
            end
            fcw_pkg::FCW_DONE: begin
               state_r <= fcw_pkg::FCW_IDLE;
            end
            default: begin
               state_r <= fcw_pkg::FCW_IDLE;
            end
         endcase
      end
   end

   assign busy_o = (state_r != fcw_pkg::FCW_IDLE);

   ////////////////////////////////////////////////////////////////////
   // register write port outputs
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wr_en_o <= 1'b0;
         wr_addr_o <= 16'h0000;
         wr_data_o <= 16'h0000;
      end else if (state_r == fcw_pkg::FCW_WRITE && left_r != 4'h0) begin
         // bytes past the count are never read
         wr_en_o <= 1'b1;
         wr_addr_o <= base_r + {12'h000, idx_r};
         wr_data_o <= be16(area_i[`FCW_BYTE_DATA + 2 * idx_r],
                           area_i[`FCW_BYTE_DATA + 2 * idx_r + 1]);
      end else begin
         wr_en_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read window start
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         win_start_o <= `FCW_ADDR_RST;
      end else if (fire && code == `FCW_CMD_WINDOW) begin
         // byte 01 plays no part here
         win_start_o <= be16(area_i[`FCW_BYTE_ADDR_HI], area_i[`FCW_BYTE_ADDR_LO]);
      end
   end

   assign win_len_o = `FCW_WIN_REGS;

   ////////////////////////////////////////////////////////////////////
   // program-reset indication, set wins over clear
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         prog_rst_o <= 1'b1;
      end else if (prog_rst_set_i) begin
         prog_rst_o <= 1'b1;
      end else if (fire && code == `FCW_CMD_CLR_RST) begin
         prog_rst_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // direct commands pass through as one-cycle strobe
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cmd_en_o <= 1'b0;
         cmd_code_o <= `FCW_CMD_NONE;
      end else begin
         cmd_en_o <= fire && code != `FCW_CMD_WRITE && code != `FCW_CMD_WINDOW
                     && code != `FCW_CMD_CLR_RST;
         if (fire) begin
            cmd_code_o <= code;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   property p_win_load;
      @(posedge clk_i) disable iff (!rstn_i)
      (fire && code == `FCW_CMD_WINDOW) |=>
         win_start_o == $past({area_i[`FCW_BYTE_ADDR_HI], area_i[`FCW_BYTE_ADDR_LO]});
   endproperty
   a_win_load: assert property (p_win_load) else $error("window start wrong");

   property p_clr;
      @(posedge clk_i) disable iff (!rstn_i)
      (fire && code == `FCW_CMD_CLR_RST && !prog_rst_set_i) |=> !prog_rst_o;
   endproperty
   a_clr: assert property (p_clr) else $error("reset bit not cleared");

   property p_direct;
      @(posedge clk_i) disable iff (!rstn_i)
      (fire && code < `FCW_CMD_WINDOW) |=> cmd_en_o && cmd_code_o == $past(code);
   endproperty
   a_direct: assert property (p_direct) else $error("direct command lost");

   property p_first_wr;
      @(posedge clk_i) disable iff (!rstn_i)
      (fire && code == `FCW_CMD_WRITE && area_i[`FCW_BYTE_CNT] != 8'h00 && !busy_o)
         |-> ##2 wr_en_o
         && wr_addr_o == $past({area_i[`FCW_BYTE_ADDR_HI], area_i[`FCW_BYTE_ADDR_LO]}, 2);
   endproperty
   a_first_wr: assert property (p_first_wr) else $error("first write missing");

   property p_max_six;
      @(posedge clk_i) disable iff (!rstn_i)
      wr_en_o |-> idx_r <= `FCW_MAX_REGS;
   endproperty
   a_max_six: assert property (p_max_six) else $error("too many registers");

   property p_no_wr_idle;
      @(posedge clk_i) disable iff (!rstn_i)
      (state_r == fcw_pkg::FCW_IDLE) |=> !wr_en_o;
   endproperty
   a_no_wr_idle: assert property (p_no_wr_idle) else $error("stray write");

   property p_len;
      @(posedge clk_i) disable iff (!rstn_i)
      win_len_o == `FCW_WIN_REGS;
   endproperty
   a_len: assert property (p_len) else $error("window length wrong");

   property p_data0;
      @(posedge clk_i) disable iff (!rstn_i)
      (state_r == fcw_pkg::FCW_WRITE && left_r != 4'h0 && idx_r == 4'h0) |=>
         wr_data_o == $past({area_i[`FCW_BYTE_DATA], area_i[`FCW_BYTE_DATA + 1]});
   endproperty
   a_data0: assert property (p_data0) else $error("first data word wrong");
endmodule : fcw_top
`default_nettype wire

/* File: verif/fcw_master_model.sv */
// Purpose: behavioural fieldbus master that fills the output area
// Assumes: area changes only at the falling clock edge
// Notes: a repeated code is preceded by a zero command byte
`default_nettype none
module fcw_master_model (
   // clock
   input wire logic clk_i,
   // output data area
   output logic [7:0] area_o [16]
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////
   // idle area: all zero
   initial begin
      for (int i = 0; i < 16; i++) area_o[i] = 8'h00;
   end
   // count, address msb first, then all data bytes
   task automatic load(input logic [7:0] cnt, input logic [15:0] adr,
                       input logic [7:0] d [12]);
      @(negedge clk_i);
      area_o[1] = cnt;
      area_o[2] = adr[15:8];
      area_o[3] = adr[7:0];
      for (int i = 0; i < 12; i++) area_o[4+i] = d[i];
   endtask : load
   // write the command byte, zeroing it first on a repeat
   task automatic issue(input logic [7:0] code);
      if (area_o[0] == code) begin
         @(negedge clk_i);
         area_o[0] = 8'h00;
      end
      @(negedge clk_i);
      area_o[0] = code;
   endtask : issue
endmodule : fcw_master_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for the command window block
// Assumes: inputs change at the falling edge only
// Notes: write data beyond the count is filled with junk
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // clock, reset, stimulus
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic prog_rst_set_i = 1'b0;
   logic [7:0] area [16];
   logic [7:0] dat [12];
   // design outputs
   logic wr_en_o, prog_rst_o, cmd_en_o, busy_o;
   logic [15:0] wr_addr_o, wr_data_o, win_start_o;
   logic [3:0] win_len_o;
   logic [7:0] cmd_code_o;
   // counters
   int error_cnt = 0;
   int cmp_count = 0;
   int wr_n, cmd_n;
   ////////////////////////////////////////////////////////////////////
   always #2.5 clk_i = ~clk_i;
   fcw_master_model m (.clk_i(clk_i), .area_o(area));
   fcw_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .area_i(area),
      .prog_rst_set_i(prog_rst_set_i), .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o),
      .wr_data_o(wr_data_o), .win_start_o(win_start_o), .win_len_o(win_len_o),
      .prog_rst_o(prog_rst_o), .cmd_en_o(cmd_en_o), .cmd_code_o(cmd_code_o),
      .busy_o(busy_o));
   ////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // watch n cycles, check each write against the loaded bytes
   task automatic obs(input int n, input logic [15:0] adr);
      wr_n = 0;
      cmd_n = 0;
      repeat (n) begin
         @(negedge clk_i);
         if (wr_en_o === 1'b1) begin
            chk(wr_addr_o, adr + 16'(wr_n));
            chk(wr_data_o, {dat[(2*wr_n)%12], dat[(2*wr_n+1)%12]});
            wr_n++;
         end
         if (cmd_en_o === 1'b1) cmd_n++;
      end
   endtask : obs
   // full write command, junk beyond first bytes
   task automatic do_write(input logic [7:0] cnt, input logic [15:0] adr, input int n);
      m.load(cnt, adr, dat);
      m.issue(8'hFB);
      obs(20, adr);
      chk(16'(wr_n), 16'(n));
      chk({15'h0000, busy_o}, 16'h0000);
      $display("test write cnt=%0d done", cnt);
   endtask : do_write
   // set pattern of data bytes
   task automatic fill(input logic [7:0] b0, b1, b2, b3, b4, b5);
      for (int i = 0; i < 12; i++) dat[i] = 8'hE0 + 8'(i);
      dat[0] = b0;
      dat[1] = b1;
      dat[2] = b2;
      dat[3] = b3;
      dat[4] = b4;
      dat[5] = b5;
   endtask : fill
   // window command, count byte set to a value that must be ignored
   task automatic t_window(input logic [7:0] cnt, input logic [15:0] adr,
                           input logic [7:0] code);
      m.load(cnt, adr, dat);
      m.issue(code);
      obs(8, 16'h0000);
      chk(win_start_o, adr);
      chk({12'h000, win_len_o}, 16'h000C);
      chk(16'(wr_n + cmd_n), 16'h0000);
      $display("test window done");
   endtask : t_window
   // clear, set again, repeat clear, then set and clear in one cycle
   task automatic t_clr(input logic [7:0] code);
      m.issue(code);
      obs(6, 16'h0000);
      chk({15'h0000, prog_rst_o}, 16'h0000);
      @(negedge clk_i);
      prog_rst_set_i = 1'b1;
      @(negedge clk_i);
      prog_rst_set_i = 1'b0;
      chk({15'h0000, prog_rst_o}, 16'h0001);
      m.issue(code);
      obs(6, 16'h0000);
      chk({15'h0000, prog_rst_o}, 16'h0000);
      // set event raised one cycle early and still high on the edge of the clear command
      m.issue(8'h00);
      prog_rst_set_i = 1'b1;
      m.issue(code);
      @(negedge clk_i);
      prog_rst_set_i = 1'b0;
      chk({15'h0000, prog_rst_o}, 16'h0001);
      $display("test clear done");
   endtask : t_clr
   // direct code, held, repeated through zero, then zero alone
   task automatic t_direct(input logic [7:0] code);
      m.issue(code);
      obs(12, 16'h0000);
      chk(16'(cmd_n), 16'h0001);
      chk({8'h00, cmd_code_o}, {8'h00, code});
      m.issue(code);
      obs(8, 16'h0000);
      chk(16'(cmd_n), 16'h0001);
      m.issue(8'h00);
      obs(8, 16'h0000);
      chk(16'(cmd_n + wr_n), 16'h0000);
      $display("test direct code=%h done", code);
   endtask : t_direct
   // closing report
   task automatic end_sim;
      $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(negedge clk_i);
      rstn_i = 1'b1;
      chk({15'h0000, prog_rst_o}, 16'h0001);
      chk(win_start_o, 16'h0000);
      fill(8'h42, 8'hF7, 8'h00, 8'h00, 8'hE4, 8'hE5);
      do_write(8'h02, 16'hB3CA, 2);
      fill(8'h00, 8'h00, 8'h30, 8'h3E, 8'h00, 8'h02);
      do_write(8'h03, 16'hA4B9, 3);
      do_write(8'h06, 16'hFFFE, 6);
      do_write(8'h09, 16'h1000, 6);
      t_window(8'h09, 16'hAC2A, 8'hFA);
      t_clr(8'hFC);
      t_direct(8'h05);
      t_direct(8'hFE);
      end_sim;
   end
endmodule : tb_top
`default_nettype wire
